/* rtl/fcwd_map.svh */
// Contract
// - holding-register address field is 16 bits, covering 65536 registers.
// - six-digit numbers 400001..465536 map to protocol addresses 0..65535.
// - five-digit numbers 40001..49999 reach 400001..409999 only; higher unreachable.
// - registers of 32-bit parameters are refused under five-digit numbering.
// - profile select: converting profile decodes bits, pass-through passes word unchanged.
// - bit 0 set advances; clear requests ramp stop.
// - bit 1 clear requests coast stop; set leaves operation alone.
// - bit 2 clear requests quick stop; set leaves operation alone.
// - bit 3 set enables operation given run enable; fieldbus may supply it.
// - bit 4 clear forces ramp generator output to zero.
// - bit 5 clear holds ramp generator output.
// - bit 6 clear zeroes ramp input, only when fieldbus is the source.
// - rising edge of bit 7 resets fault, only when fieldbus is source.
// - bit 10 enables fieldbus control; clear keeps last word or locks.
// - bit 11 selects location two, else one, when fieldbus selects location.
// - bits 12 to 15 are user bits passed to application logic.
// - command and state words are 16 bits, 32 under pass-through.
`ifndef FCWD_MAP_SVH
`define FCWD_MAP_SVH
`define FCWD_BIT_RAMP_STOP 0
`define FCWD_BIT_COAST_STOP 1
`define FCWD_BIT_QUICK_STOP 2
`define FCWD_BIT_RUN 3
`define FCWD_BIT_OUT_ZERO 4
`define FCWD_BIT_HOLD 5
`define FCWD_BIT_IN_ZERO 6
`define FCWD_BIT_RESET 7
`define FCWD_BIT_REMOTE 10
`define FCWD_BIT_LOCATION 11
`define FCWD_USER_HI 15
`define FCWD_USER_LO 12
`define FCWD_SIX_BASE 20'h61a81
`define FCWD_SIX_TOP 20'h71a80
`define FCWD_FIVE_BASE 20'h09c41
`define FCWD_FIVE_TOP 20'h0c34f
`define FCWD_WORD_RESET 32'h0000_0000
`define FCWD_REF_RESET 32'h0000_0000
`endif

/* rtl/fcwd_pkg.sv */
package fcwd_pkg;
  typedef enum logic {
    FCWD_CONVERTING,
    FCWD_PASSTHROUGH
  } fcwd_profile_type;
  typedef enum logic {
    FCWD_SIX_DIGIT,
    FCWD_FIVE_DIGIT
  } fcwd_numbering_type;
endpackage

/* rtl/fcwd_decoder.sv */
`timescale 1ns/1ps
`include "fcwd_map.svh"
module fcwd_decoder (
  input wire logic clk,
  input wire logic rst,
  input wire fcwd_pkg::fcwd_profile_type profileSel,
  input wire fcwd_pkg::fcwd_numbering_type numberingSel,
  input wire logic wordWrite,
  input wire logic [31:0] commandWord,
  input wire logic [31:0] referenceIn,
  input wire logic [19:0] registerNumber,
  input wire logic registerIs32,
  input wire logic fieldbusRunEnableSrc,
  input wire logic fieldbusInZeroSrc,
  input wire logic fieldbusResetSrc,
  input wire logic fieldbusLocationSrc,
  input wire logic runEnableIn,
  output logic [15:0] registerAddr_r,
  output logic registerValid_r,
  output logic rampStopReq_r,
  output logic coastStopReq_r,
  output logic quickStopReq_r,
  output logic operationEnable_r,
  output logic rampOutZero_r,
  output logic rampHold_r,
  output logic rampInZero_r,
  output logic faultReset_r,
  output logic remoteControl_r,
  output logic lockRefRamps_r,
  output logic locationSelect_r,
  output logic [3:0] userBits_r,
  output logic [31:0] driveWord_r,
  output logic [31:0] heldReference_r
);
  import fcwd_pkg::*;

  logic [31:0] commandWordReg_r;
  logic [31:0] prevWord_r;
  logic pendingEdge_r;
  logic [31:0] writeReference_r;
  logic [15:0] registerAddr_nxt;
  logic registerValid_nxt;

  function automatic logic cbit(input logic [31:0] w, input int idx);
    return w[idx];
  endfunction

  // address translation
  always_comb begin
    registerAddr_nxt = 16'h0000;
    registerValid_nxt = 1'b0;
    if (numberingSel == FCWD_SIX_DIGIT) begin
      if (registerNumber >= `FCWD_SIX_BASE && registerNumber <= `FCWD_SIX_TOP) begin
        registerAddr_nxt = 16'(registerNumber - `FCWD_SIX_BASE);
        registerValid_nxt = 1'b1;
      end
    end else begin
      if (registerNumber >= `FCWD_FIVE_BASE && registerNumber <= `FCWD_FIVE_TOP
          && !registerIs32) begin
        registerAddr_nxt = 16'(registerNumber - `FCWD_FIVE_BASE);
        registerValid_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      registerAddr_r <= 16'h0000;
      registerValid_r <= 1'b0;
    end else begin
      registerAddr_r <= registerAddr_nxt;
      registerValid_r <= registerValid_nxt;
    end
  end

  // command word capture
  always_ff @(posedge clk) begin
    if (rst) begin
      commandWordReg_r <= `FCWD_WORD_RESET;
      prevWord_r <= `FCWD_WORD_RESET;
      heldReference_r <= `FCWD_REF_RESET;
      writeReference_r <= `FCWD_REF_RESET;
      pendingEdge_r <= 1'b0;
    end else begin
      pendingEdge_r <= wordWrite;
      if (wordWrite) begin
        prevWord_r <= commandWordReg_r;
        // reference of the latest write, held or not, decides the lock
        writeReference_r <= referenceIn;
        if (profileSel == FCWD_PASSTHROUGH) begin
          commandWordReg_r <= commandWord;
        end else begin
          commandWordReg_r <= {16'h0000, commandWord[15:0]};
        end
        if (profileSel == FCWD_PASSTHROUGH || commandWord[`FCWD_BIT_REMOTE]) begin
          heldReference_r <= referenceIn;
        end
      end
    end
  end

  // converting profile decode
  always_ff @(posedge clk) begin
    if (rst) begin
      rampStopReq_r <= 1'b1;
      coastStopReq_r <= 1'b1;
      quickStopReq_r <= 1'b1;
      operationEnable_r <= 1'b0;
      rampOutZero_r <= 1'b1;
      rampHold_r <= 1'b1;
      rampInZero_r <= 1'b1;
      faultReset_r <= 1'b0;
      remoteControl_r <= 1'b0;
      lockRefRamps_r <= 1'b0;
      locationSelect_r <= 1'b0;
      userBits_r <= 4'h0;
      driveWord_r <= `FCWD_WORD_RESET;
    end else begin
      faultReset_r <= 1'b0;
      if (profileSel == FCWD_PASSTHROUGH) begin
        driveWord_r <= commandWordReg_r;
      end else begin
        driveWord_r <= `FCWD_WORD_RESET;
        if (cbit(commandWordReg_r, `FCWD_BIT_REMOTE)) begin
          remoteControl_r <= 1'b1;
          lockRefRamps_r <= 1'b0;
          rampStopReq_r <= !cbit(commandWordReg_r, `FCWD_BIT_RAMP_STOP);
          coastStopReq_r <= !cbit(commandWordReg_r, `FCWD_BIT_COAST_STOP);
          quickStopReq_r <= !cbit(commandWordReg_r, `FCWD_BIT_QUICK_STOP);
          operationEnable_r <= cbit(commandWordReg_r, `FCWD_BIT_RUN)
              && (fieldbusRunEnableSrc || runEnableIn);
          rampOutZero_r <= !cbit(commandWordReg_r, `FCWD_BIT_OUT_ZERO);
          rampHold_r <= !cbit(commandWordReg_r, `FCWD_BIT_HOLD);
          rampInZero_r <= fieldbusInZeroSrc
              && !cbit(commandWordReg_r, `FCWD_BIT_IN_ZERO);
          if (pendingEdge_r && fieldbusResetSrc && cbit(commandWordReg_r, `FCWD_BIT_RESET)
              && !cbit(prevWord_r, `FCWD_BIT_RESET)) begin
            faultReset_r <= 1'b1;
          end
          if (fieldbusLocationSrc) begin
            locationSelect_r <= cbit(commandWordReg_r, `FCWD_BIT_LOCATION);
          end
          userBits_r <= commandWordReg_r[`FCWD_USER_HI:`FCWD_USER_LO];
        end else begin
          remoteControl_r <= 1'b0;
          // zero word and reference: lock; remoteControl_r and faultReset_r clear, driveWord_r is zero, other outputs keep last values
          lockRefRamps_r <= (commandWordReg_r[15:0] == 16'h0000)
              && (writeReference_r == `FCWD_REF_RESET);
        end
      end
    end
  end
endmodule // fcwd_decoder

/* tb/fcwd_master_model.sv */
`timescale 1ns/1ps
module fcwd_master_model (
  input wire logic clk,
  output logic wordWrite,
  output logic [31:0] commandWord,
  output logic [31:0] referenceIn
);
  initial {wordWrite, commandWord, referenceIn} = '0;
  task put(input logic [31:0] w, r);
    @(posedge clk) #1;
    {wordWrite, commandWord, referenceIn} = {1'b1, w, r};
    @(posedge clk) #1;
    {wordWrite, commandWord, referenceIn} = {1'b0, ~w, ~r};
  endtask
endmodule // fcwd_master_model

/* tb/fcwd_decoder_monitor.sv */
`timescale 1ns/1ps
module fcwd_decoder_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire fcwd_pkg::fcwd_profile_type profileSel,
  input wire fcwd_pkg::fcwd_numbering_type numberingSel,
  input wire logic wordWrite,
  input wire logic [31:0] commandWord,
  input wire logic [19:0] registerNumber,
  input wire logic [15:0] registerAddr_r,
  input wire logic registerValid_r,
  input wire logic rampStopReq_r,
  input wire logic coastStopReq_r,
  input wire logic remoteControl_r,
  input wire logic faultReset_r,
  input wire logic [3:0] userBits_r
);
  import fcwd_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic decodeWrite = wordWrite && commandWord[10] && !profileSel;
  chk_ramp_stop: assert property (decodeWrite |-> ##2
    rampStopReq_r != $past(commandWord[0], 2)) else $error("ramp stop");
  chk_coast_stop: assert property (decodeWrite |-> ##2
    coastStopReq_r != $past(commandWord[1], 2)) else $error("coast stop");
  chk_user_bits: assert property (decodeWrite |-> ##2
    userBits_r == $past(commandWord[15:12], 2)) else $error("user bits");
  chk_remote_level: assert property (wordWrite && !profileSel |-> ##2
    remoteControl_r == $past(commandWord[10], 2)) else $error("remote");
  chk_fault_pulse: assert property (faultReset_r |=> !faultReset_r)
    else $error("fault pulse");
  chk_fault_cause: assert property (faultReset_r |->
    $past(wordWrite, 2) && $past(commandWord[7], 2)) else $error("fault cause");
  chk_six_map: assert property (!numberingSel && registerNumber >= 20'h61a81 &&
    registerNumber <= 20'h71a80 |=> registerValid_r &&
    registerAddr_r == 16'($past(registerNumber) - 20'h61a81)) else $error("six map");
  chk_six_low: assert property (!numberingSel && registerNumber < 20'h61a81 |=> !registerValid_r)
    else $error("six low");
  chk_five_limit: assert property (numberingSel && registerNumber > 20'h0c34f |=> !registerValid_r)
    else $error("five limit");
endmodule // fcwd_decoder_monitor
bind fcwd_decoder fcwd_decoder_monitor i_mon (.*);

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import fcwd_pkg::*;
  logic clk, rst, wordWrite, registerIs32, runEnableIn, registerValid_r;
  logic fieldbusRunEnableSrc, fieldbusInZeroSrc, fieldbusResetSrc, fieldbusLocationSrc;
  fcwd_profile_type profileSel;
  fcwd_numbering_type numberingSel;
  logic [19:0] registerNumber;
  logic [31:0] commandWord, referenceIn, driveWord_r, heldReference_r;
  logic [15:0] registerAddr_r;
  logic [3:0] userBits_r;
  logic rampStopReq_r, coastStopReq_r, quickStopReq_r, operationEnable_r, rampOutZero_r;
  logic rampHold_r, rampInZero_r, faultReset_r, remoteControl_r, lockRefRamps_r, locationSelect_r;
  logic [15:0] wl[4] = '{16'h047f, 16'h0c8a, 16'hf455, 16'h0530};
  int errorCnt = 0;
  int cmpCount = 0;
  fcwd_decoder i_dut (.*);
  fcwd_master_model i_host (.*);
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [31:0] s, e);
    cmpCount++;
    if (s !== e) begin
      errorCnt++;
      $display("wrong value %0t %h %h", $time, s, e);
    end
  endtask
  task finalReport;
    if (errorCnt == 0 && cmpCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task put(input logic [31:0] w, r);
    i_host.put(w, r);
    @(posedge clk) #1;
  endtask
  task dec(input logic [15:0] w);
    put({16'h0, w}, 32'h0);
    chk({rampStopReq_r, coastStopReq_r, quickStopReq_r}, {!w[0], !w[1], !w[2]});
    chk({rampOutZero_r, rampHold_r, rampInZero_r}, {!w[4], !w[5], !w[6]});
    chk({locationSelect_r, userBits_r, operationEnable_r}, {w[11], w[15:12], w[3]});
    chk({remoteControl_r, lockRefRamps_r}, 2'h2);
  endtask
  task ad(input logic f, b, input logic [19:0] n, input logic [16:0] e);
    numberingSel = fcwd_numbering_type'(f);
    registerIs32 = b;
    registerNumber = n;
    @(posedge clk) #1;
    chk({registerValid_r, registerValid_r ? registerAddr_r : 16'h0}, e);
  endtask
  initial begin
    rst = 1;
    profileSel = FCWD_CONVERTING;
    numberingSel = FCWD_SIX_DIGIT;
    {registerIs32, runEnableIn, registerNumber} = '0;
    {fieldbusRunEnableSrc, fieldbusInZeroSrc, fieldbusResetSrc, fieldbusLocationSrc} = 4'hf;
    repeat (8) @(posedge clk);
    #1 rst = 0;
    chk({rampStopReq_r, faultReset_r}, 2'h2);
    chk(heldReference_r, 32'h0);
    foreach (wl[i]) dec(wl[i]);
    {fieldbusRunEnableSrc, fieldbusInZeroSrc, fieldbusLocationSrc} = 3'h0;
    put(32'h0c08, 32'h0);
    chk({operationEnable_r, rampInZero_r, locationSelect_r}, 3'h0);
    {fieldbusRunEnableSrc, fieldbusInZeroSrc, fieldbusLocationSrc} = 3'h7;
    for (int s = 0; s < 2; s++) begin
      fieldbusResetSrc = s[0];
      put(32'h0400, 32'h0);
      put(32'h0480, 32'h1234);
      chk(faultReset_r, s[0]);
      @(posedge clk) #1;
      chk(faultReset_r, 1'h0);
    end
    put(32'h0001, 32'h5);
    chk({rampStopReq_r, lockRefRamps_r, heldReference_r[15:0]}, 18'h2_1234);
    put(32'h0, 32'h0);
    chk({remoteControl_r, lockRefRamps_r}, 2'h1);
    profileSel = FCWD_PASSTHROUGH;
    put(32'hdead_beef, 32'h0);
    chk(driveWord_r, 32'hdead_beef);
    profileSel = FCWD_CONVERTING;
    ad(0, 0, 20'h61a81, 17'h10000);
    ad(0, 0, 20'h71a80, 17'h1ffff);
    ad(0, 0, 20'h71a81, 17'h0);
    ad(0, 0, 20'h61a80, 17'h0);
    ad(0, 1, 20'h61a8a, 17'h10009);
    ad(1, 0, 20'h09c41, 17'h10000);
    ad(1, 0, 20'h0c34f, 17'h1270e);
    ad(1, 0, 20'h0c350, 17'h0);
    ad(1, 1, 20'h09c42, 17'h0);
    finalReport;
  end
endmodule // tb
